/* hdl/icf_core.sv */
`timescale 1ns/1ps
`default_nettype none
module icf_core #(
  parameter int EXT_N = icf_pkg::EXT_N
) (
  input wire logic clk,
  input wire logic rst,
  input wire icf_pkg::icf_bus_t bus,
  output logic [15:0] rdata,
  input wire icf_pkg::icf_trap_t trap_evt,
  input wire logic [EXT_N-1:0] ext_pin,
  input wire logic [47:0] periph_evt,
  input wire logic [2:0] ipl_wdata,
  input wire logic ipl_we,
  output logic [2:0] cpu_priority_level_bits,
  input wire logic new_irq_pending,
  input wire logic in_service,
  output logic preempt_allow,
  input wire logic disable_instruction_active,
  output logic nesting_disable,
  output logic alternate_table_select,
  output logic [47:0] flags,
  output logic irq
);
  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [15:0] flag0_r;
  logic [15:0] flag1_r;
  logic [15:0] flag2_r;
  logic [15:0] ist_r;
  logic [15:0] imask_r;
  logic [2:0] ipl_r;
  logic [15:0] trap_set;
  logic [15:0] ext_set0;
  logic [15:0] ext_set1;
  logic [EXT_N-1:0] ext_hit;
  logic [15:0] ist_set;
  logic wr1;
  logic wr2;
  logic wf0;
  logic wf1;
  logic wf2;

  // Flag positions of external inputs 1 and 2 in flag register 1.
  localparam int EXT1_FLAG_BIT = 4;
  localparam int EXT2_FLAG_BIT = 13;

  assign wr1 = bus.wr && bus.addr == icf_pkg::ADR_CTRL1;
  assign wr2 = bus.wr && bus.addr == icf_pkg::ADR_CTRL2;
  assign wf0 = bus.wr && bus.addr == icf_pkg::ADR_FLAG0;
  assign wf1 = bus.wr && bus.addr == icf_pkg::ADR_FLAG1;
  assign wf2 = bus.wr && bus.addr == icf_pkg::ADR_FLAG2;

  genvar gi;
  generate
    for (gi = 0; gi < EXT_N; gi = gi + 1) begin : g_ext
      icf_ext_edge u_edge (
        .clk(clk),
        .rst(rst),
        .pin(ext_pin[gi]),
        .neg_edge(ctrl2_r[gi]),
        .hit(ext_hit[gi])
      );
    end
  endgenerate

  // Trap events gathered into their register positions.
  always_comb begin
    trap_set = icf_pkg::ZERO16;
    trap_set[icf_pkg::TRAP_LSB +: icf_pkg::TRAP_N] = trap_evt;
  end

  // External pins 0..2 feed their flag positions; pins 3 and 4 reach no flag bit.
  always_comb begin
    ext_set0 = icf_pkg::ZERO16;
    ext_set1 = icf_pkg::ZERO16;
    ext_set0[icf_pkg::FLAG0_EXT0] = ext_hit[0];
    ext_set1[EXT1_FLAG_BIT] = ext_hit[1];
    ext_set1[EXT2_FLAG_BIT] = ext_hit[2];
  end

  // Control 1: nesting bit writable, trap bits sticky; set wins over a clearing write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1_r <= icf_pkg::ZERO16;
    end else if (wr1) begin
      ctrl1_r <= (bus.wdata | trap_set) & icf_pkg::CTRL1_MASK;
    end else begin
      ctrl1_r <= ctrl1_r | trap_set;
    end
  end

  // Control 2: alternate table and polarities writable; the busy bit mirrors the core.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl2_r <= icf_pkg::ZERO16;
    end else begin
      ctrl2_r <= wr2 ? (bus.wdata & icf_pkg::CTRL2_WMASK) : (ctrl2_r & icf_pkg::CTRL2_WMASK);
      ctrl2_r[icf_pkg::DISABLE_INSTRUCTION_ACTIVE_BIT] <= disable_instruction_active;
    end
  end

  // Flags: source events set, software writes any value, a set in the same cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag0_r <= icf_pkg::ZERO16;
      flag1_r <= icf_pkg::ZERO16;
      flag2_r <= icf_pkg::ZERO16;
    end else begin
      flag0_r <= ((wf0 ? bus.wdata : flag0_r) | periph_evt[15:0] | ext_set0) & icf_pkg::FLAG0_MASK;
      flag1_r <= ((wf1 ? bus.wdata : flag1_r) | periph_evt[31:16] | ext_set1) & icf_pkg::FLAG1_MASK;
      flag2_r <= ((wf2 ? bus.wdata : flag2_r) | periph_evt[47:32]) & icf_pkg::FLAG2_MASK;
    end
  end

  // CPU priority level: software may change it only while nesting is allowed.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ipl_r <= icf_pkg::IPL_RESET;
    end else if (ipl_we && !ctrl1_r[icf_pkg::NEST_DIS_BIT]) begin
      ipl_r <= ipl_wdata;
    end
  end

  // Interrupt status: sticky, write one to clear, new events win.
  always_comb begin
    ist_set = icf_pkg::ZERO16;
    ist_set[icf_pkg::IRQ_TRAP_BIT] = |trap_evt;
    ist_set[icf_pkg::IRQ_FLAG_BIT] = |periph_evt | |ext_hit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r <= icf_pkg::ZERO16;
    end else begin
      ist_r <= ((bus.wr && bus.addr == icf_pkg::ADR_IRQ_STAT) ? (ist_r & ~bus.wdata) : ist_r)
               | (ist_set & icf_pkg::IRQ_MASK_BITS);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      imask_r <= icf_pkg::ZERO16;
    end else if (bus.wr && bus.addr == icf_pkg::ADR_IRQ_MASK) begin
      imask_r <= bus.wdata & icf_pkg::IRQ_MASK_BITS;
    end
  end

  // Read data stands in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= icf_pkg::ZERO16;
    end else if (bus.rd) begin
      case (bus.addr)
        icf_pkg::ADR_CTRL1: rdata <= ctrl1_r;
        icf_pkg::ADR_CTRL2: rdata <= ctrl2_r;
        icf_pkg::ADR_FLAG0: rdata <= flag0_r;
        icf_pkg::ADR_FLAG1: rdata <= flag1_r;
        icf_pkg::ADR_FLAG2: rdata <= flag2_r;
        icf_pkg::ADR_IRQ_STAT: rdata <= ist_r;
        icf_pkg::ADR_IRQ_MASK: rdata <= imask_r;
        default: rdata <= icf_pkg::ZERO16;
      endcase
    end else begin
      rdata <= icf_pkg::ZERO16;
    end
  end

  assign nesting_disable = ctrl1_r[icf_pkg::NEST_DIS_BIT];
  assign preempt_allow = new_irq_pending && !(in_service && nesting_disable);
  assign alternate_table_select = ctrl2_r[icf_pkg::ALT_TABLE_BIT];
  assign cpu_priority_level_bits = ipl_r;
  assign flags = {flag2_r, flag1_r, flag0_r};
  assign irq = |(ist_r & imask_r);
endmodule : icf_core
`default_nettype wire

/* hdl/icf_pkg.sv */
package icf_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int EXT_N = 5;
  localparam int TRAP_N = 6;
  localparam int FLAG_N = 48;

  // Register indices.
  localparam logic [3:0] ADR_CTRL1 = 4'h0;
  localparam logic [3:0] ADR_CTRL2 = 4'h1;
  localparam logic [3:0] ADR_FLAG0 = 4'h2;
  localparam logic [3:0] ADR_FLAG1 = 4'h3;
  localparam logic [3:0] ADR_FLAG2 = 4'h4;
  localparam logic [3:0] ADR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADR_IRQ_MASK = 4'h6;

  // Control register 1 fields.
  localparam int NEST_DIS_BIT = 15;
  localparam int TRAP_LSB = 1;
  localparam logic [15:0] CTRL1_MASK = 16'h807E;

  // Control register 2 fields.
  localparam int ALT_TABLE_BIT = 15;
  localparam int DISABLE_INSTRUCTION_ACTIVE_BIT = 14;
  localparam logic [15:0] CTRL2_WMASK = 16'h801F;

  // Implemented flag bits.
  localparam logic [15:0] FLAG0_MASK = 16'h7FFF;
  localparam logic [15:0] FLAG1_MASK = 16'hFFFB;
  localparam logic [15:0] FLAG2_MASK = 16'hDFFF;
  localparam int FLAG0_EXT0 = 0;
  localparam int FLAG0_CAP1 = 1;
  localparam int FLAG0_CMP1 = 2;
  localparam int FLAG1_I2C_SLV = 0;
  localparam int FLAG1_I2C_MST = 1;
  localparam int FLAG1_CHG = 3;
  localparam int FLAG2_SPI_ERR = 0;
  localparam int FLAG2_SPI_EVT = 1;
  localparam int FLAG2_CAN_RX = 2;

  // Interrupt status bits: trap taken, any peripheral or external pin event.
  localparam int IRQ_TRAP_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  localparam logic [15:0] IRQ_MASK_BITS = 16'h0003;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [2:0] IPL_RESET = 3'h0;

  typedef struct packed {
    logic div0;
    logic dma;
    logic math;
    logic addr;
    logic stack;
    logic osc;
  } icf_trap_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } icf_bus_t;
endpackage : icf_pkg

/* hdl/icf_ext_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// Synchronises one external interrupt pin and pulses on the selected edge.
module icf_ext_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic neg_edge,
  output logic hit
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The accepted level follows the pin only while the second and third stages agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  // An edge is one pulse when the agreed level leaves the accepted one in the selected direction.
  assign hit = (s2_r == s3_r) && (s3_r != level_r) && (neg_edge ? !s3_r : s3_r);
endmodule : icf_ext_edge
`default_nettype wire

/* tb/icf_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module icf_sva (
  input wire logic clk,
  input wire logic rst,
  input wire icf_pkg::icf_bus_t bus,
  input wire logic [15:0] rdata,
  input wire icf_pkg::icf_trap_t trap_evt,
  input wire logic [47:0] periph_evt,
  input wire logic ipl_we,
  input wire logic [2:0] cpu_priority_level_bits,
  input wire logic nesting_disable,
  input wire logic [47:0] flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_trap;
    trap_evt.div0 ##1 !bus.wr;
  endsequence
  sequence s_rd_ctrl1;
    bus.rd && bus.addr == 4'h0;
  endsequence
  AST_DIV0: assert property (s_trap ##1 s_rd_ctrl1 |=> rdata[6]) else $error("div0 lost");
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 16'h0000) else $error("rdata not idle");
  AST_UNIMP: assert property ($past(bus.rd && bus.addr == 4'h0) |-> !(rdata & ~icf_pkg::CTRL1_MASK))
    else $error("ctrl1 reserved bit");
  AST_BIT2: assert property ($past(bus.rd && bus.addr == 4'h3) |-> !rdata[2]) else $error("bit2 set");
  AST_NEST: assert property (bus.wr && bus.addr == 4'h0 |=>
    nesting_disable == $past(bus.wdata[15])) else $error("nest bit");
  AST_IPL: assert property (ipl_we && nesting_disable |=> $stable(cpu_priority_level_bits))
    else $error("ipl written");
  AST_SET: assert property (periph_evt[19] |=> flags[19]) else $error("flag not set");
  AST_HOLD: assert property (flags[0] && !(bus.wr && bus.addr == 4'h2) |=> flags[0])
    else $error("flag dropped");
endmodule : icf_sva
bind icf_core icf_sva chk (.*);
`default_nettype wire

/* tb/icf_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module icf_partner (
  input wire logic clk,
  output var icf_pkg::icf_trap_t trap_evt,
  output var logic [47:0] periph_evt,
  output var logic [4:0] ext_pin
);
  initial begin
    trap_evt = '0;
    periph_evt = 48'h0;
    ext_pin = 5'h00;
  end
  // Trap and peripheral sources pulse one cycle only, so a flag must latch on its own.
  task automatic drive(input logic [47:0] e, input logic [5:0] t, input logic pin);
    @(posedge clk);
    periph_evt <= e;
    trap_evt <= icf_pkg::icf_trap_t'(t);
    ext_pin <= {5{pin}};
    @(posedge clk);
    periph_evt <= 48'h0;
    trap_evt <= '0;
  endtask : drive
endmodule : icf_partner
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, ipl_we, in_service, new_irq_pending, preempt_allow, irq;
  logic disable_instruction_active, nesting_disable, alternate_table_select;
  icf_pkg::icf_bus_t bus;
  icf_pkg::icf_trap_t trap_evt;
  logic [15:0] rdata;
  logic [4:0] ext_pin;
  logic [47:0] periph_evt, flags;
  logic [2:0] ipl_wdata, cpu_priority_level_bits;
  int n_fail = 0;
  int n_tests = 0;
  icf_core uut (.*);
  icf_partner p (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, w, !w};
    @(posedge clk);
    bus <= '{a, d, 1'b0, 1'b0};
    #1 if (!w) chk(48'(rdata), 48'(d));
  endtask : acc
  task automatic t_ctrl;
    for (int a = 0; a < 16; a++) acc(0, 4'(a), 16'h0000);
    acc(1, 4'h0, 16'hFFFF);
    acc(0, 4'h0, 16'h807E);
    for (int n = 1; n >= 0; n--) begin
      ipl_we <= 1'b1;
      @(posedge clk);
      ipl_we <= 1'b0;
      #1 chk(48'(cpu_priority_level_bits), n ? 48'h0 : 48'h7);
      chk(48'(preempt_allow), 48'(!n));
      acc(1, 4'h0, 16'h0000);
    end
  endtask : t_ctrl
  task automatic t_trap;
    for (int i = 0; i < 6; i++) begin
      acc(1, 4'h0, 16'h0000);
      p.drive(48'h0, 6'(1 << i), 1'b0);
      acc(0, 4'h0, 16'(2 << i));
      #50 acc(0, 4'h0, 16'(2 << i));
    end
    chk(48'(irq), 48'h0);
    acc(1, 4'h6, 16'h0001);
    #21 chk(48'(irq), 48'h1);
    acc(1, 4'h0, 16'h0000);
    acc(1, 4'h5, 16'h0001);
    #21 chk(48'(irq), 48'h0);
  endtask : t_trap
  task automatic t_flag;
    logic [15:0] m[3];
    m = '{icf_pkg::FLAG0_MASK, icf_pkg::FLAG1_MASK, icf_pkg::FLAG2_MASK};
    for (int k = 0; k < 3; k++) begin
      p.drive(48'hFFFF << (16 * k), 6'h00, 1'b0);
      acc(0, 4'(2 + k), m[k]);
      chk(flags, 48'(m[k]) << (16 * k));
      acc(1, 4'(2 + k), 16'h0000);
      acc(0, 4'(2 + k), 16'h0000);
    end
  endtask : t_flag
  task automatic t_ext;
    disable_instruction_active <= 1'b1;
    acc(1, 4'h1, 16'hFFFF);
    acc(0, 4'h1, 16'hC01F);
    chk(48'(alternate_table_select), 48'h1);
    for (int v = 1; v >= 0; v--) begin
      p.drive(48'h0, 6'h00, v[0]);
      #90 acc(0, 4'h2, 16'(!v));
    end
    acc(1, 4'h1, 16'h0000);
    acc(1, 4'h2, 16'h0000);
    p.drive(48'h0, 6'h00, 1'b1);
    #90 acc(0, 4'h2, 16'h0001);
    chk(48'(alternate_table_select), 48'h0);
  endtask : t_ext
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    rst = 1'b1;
    bus = '0;
    ipl_wdata = 3'h7;
    {ipl_we, in_service, disable_instruction_active, new_irq_pending} = 4'h5;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_trap();
    t_flag();
    t_ext();
    complete_run();
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
